/* File: verilog/ptx_pkg.sv */
package ptx_pkg;

    // Byte offsets of the registers on the Avalon-MM slave.
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFF_XCVR_STATUS = 12'h280;
    localparam logic [11:0] OFF_CFG_COMMAND = 12'h2A0;
    localparam logic [11:0] OFF_CFG_RDATA   = 12'h2A4;
    localparam logic [11:0] OFF_CFG_LOCK    = 12'h2A8;
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h2AC;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h2B0;
    localparam logic [11:0] OFF_FRAMING     = 12'h4FC;
    localparam logic [11:0] OFF_S2_HTOTAL   = 12'h500;
    localparam logic [11:0] OFF_S2_VTOTAL   = 12'h504;

    // Field positions inside the status registers.
    localparam int RST_DONE01_LO  = 0;
    localparam int RST_DONE23_LO  = 2;
    localparam int PLL01_BIT      = 4;
    localparam int PLL23_BIT      = 5;
    localparam int FABRIC_PLL_BIT = 6;
    localparam int LANE_FIELD_LO  = 16;
    localparam int LANE_STRIDE    = 4;
    localparam int FRAME_STRIDE   = 8;
    localparam int LOCK_BIT       = 0;
    localparam int FRAMING_DATA_W = 32;

    // Interrupt event positions.
    localparam int IRQ_W           = 2;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_FRAMING_BIT = 1;

    // Values after reset.
    localparam logic [31:0]    CMD_RESET    = 32'h0000_0000;
    localparam logic [15:0]    TOTAL_RESET  = 16'h0000;
    localparam logic [15:0]    RDATA_RESET  = 16'h0000;
    localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;

    // Command word as software writes it.
    typedef struct packed {
        logic [15:0] wdata;
        logic        write;
        logic [6:0]  unused;
        logic [7:0]  addr;
    } ptx_cmd_t;

    // One lane nibble of the transceiver status word.
    typedef struct packed {
        logic [1:0] error;
        logic [1:0] buffer;
    } ptx_lane_stat_t;

    // Answer of the configuration port engine.
    typedef struct packed {
        logic        done;
        logic [15:0] rdata;
    } ptx_cfg_resp_t;

endpackage

/* File: verilog/ptx_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module ptx_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,   // Block clock.
    input  wire logic         arst_n_i,  // Asynchronous reset, active low.
    input  wire logic [W-1:0] async_i,   // Levels from foreign domains.
    output logic      [W-1:0] sync_o     // Levels safe to use.
);

    logic [W-1:0] stage1;

    // Two flip-flops; only the second stage reads the first.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ptx_cfg_port.sv */
`timescale 1ns/100ps
`default_nettype none

module ptx_cfg_port #(
    parameter int NUM_CH = 4
) (
    input  wire logic              clock_i,   // Block clock.
    input  wire logic              arst_n_i,  // Reset, active low.
    input  wire logic              start_i,   // Launch one command.
    input  wire ptx_pkg::ptx_cmd_t cmd_i,     // Command fields.
    input  wire logic              hold_i,    // Core owns the port.
    output logic                   busy_o,    // Command in flight.
    output ptx_pkg::ptx_cfg_resp_t resp_o,    // Done pulse and data.
    output logic [NUM_CH-1:0]      en_o,      // Port enable per channel.
    output logic                   we_o,      // Port write enable.
    output logic [7:0]             addr_o,    // Port address.
    output logic [15:0]            wdata_o,   // Port write data.
    input  wire logic [NUM_CH-1:0] rdy_i,     // Port ready per channel.
    input  wire logic [15:0]       rdata_i    // Channel 0 read data.
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PEND = 3'b010,
        ST_WAIT = 3'b100
    } ptx_cfg_st_t;

    ptx_cfg_st_t       state;
    logic [NUM_CH-1:0] seen;
    wire  [NUM_CH-1:0] next_seen = seen | rdy_i;
    wire               issue     = (state == ST_PEND) && !hold_i;
    wire               all_seen  = &next_seen;

    assign busy_o = (state != ST_IDLE);

    // The command waits while the core's own machine holds the port.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state   <= ST_IDLE;
            seen    <= '0;
            en_o    <= '0;
            we_o    <= 1'b0;
            addr_o  <= 8'h00;
            wdata_o <= 16'h0000;
            resp_o  <= '0;
        end else begin
            en_o        <= '0;
            resp_o.done <= 1'b0;
            unique case (state)
                ST_IDLE: if (start_i) begin
                    state   <= ST_PEND;
                    we_o    <= cmd_i.write;
                    addr_o  <= cmd_i.addr;
                    wdata_o <= cmd_i.write ? cmd_i.wdata : 16'h0000;
                end
                ST_PEND: if (issue) begin
                    en_o  <= '1;
                    seen  <= '0;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    seen <= next_seen;
                    if (rdy_i[0] && !we_o) begin
                        resp_o.rdata <= rdata_i;
                    end
                    if (all_seen) begin
                        resp_o.done <= 1'b1;
                        state       <= ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ptx_regs.sv */
// Behaviour
// - Reset done pairs in status bits 3:0.
// - PLL locks in status bits 4, 5, 6.
// - Per lane buffer and error nibbles from 16.
// - Command holds address, direction, write payload.
// - One command drives every channel alike.
// - Read commands ignore the payload field.
// - Read data captured when port ready.
// - Lock bit shows core using the port.
// - Framing status valid only at 32 bits.
// - Two-bit framing code per stream, stride 8.
// - Stream two line length in clocks.
// - Stream two lines per frame.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module ptx_regs #(
    parameter int NUM_LANES   = 4,
    parameter int NUM_STREAMS = 4,
    parameter int XCVR_DATA_W = 32
) (
    input  wire logic        clock_i,               // 20 MHz clock.
    input  wire logic        arst_n_i,              // Reset, active low.
    input  wire logic [11:0] avs_address_i,         // Byte address.
    input  wire logic        avs_read_i,            // Read request.
    input  wire logic        avs_write_i,           // Write request.
    input  wire logic [31:0] avs_writedata_i,       // Write data.
    input  wire logic [3:0]  avs_byteenable_i,      // Byte lanes.
    output logic      [31:0] avs_readdata_o,        // Read data.
    output logic             avs_waitrequest_o,     // Stall request.
    output logic             irq_o,                 // Level interrupt.
    input  wire logic [3:0]  xcvr_reset_done_i,     // Lane reset done.
    input  wire logic [1:0]  xcvr_pll_lock_i,       // Lane pair PLLs.
    input  wire logic        fabric_pll_lock_i,     // Fabric clock PLL.
    input  wire logic [2*NUM_LANES-1:0] lane_buf_i, // Buffer status.
    input  wire logic [2*NUM_LANES-1:0] lane_err_i, // Transmit error.
    input  wire logic [2*NUM_STREAMS-1:0] framing_err_i, // Frame codes.
    input  wire logic        core_port_busy_i,      // Core owns port.
    output logic [NUM_LANES-1:0] cfg_en_o,          // Port enables.
    output logic             cfg_we_o,              // Port write.
    output logic      [7:0]  cfg_addr_o,            // Port address.
    output logic      [15:0] cfg_wdata_o,           // Port write data.
    input  wire logic [NUM_LANES-1:0] cfg_rdy_i,    // Port ready.
    input  wire logic [15:0] cfg_rdata_i,           // Port read data.
    output logic      [15:0] s2_htotal_o,           // Line length.
    output logic      [15:0] s2_vtotal_o            // Lines per frame.
);

    localparam int SYNC_W = 7 + 4 * NUM_LANES + 2 * NUM_STREAMS;

    // Merges the enabled byte lanes of a write into an old word.
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Status pins come from transceiver clocks, so they are synchronised.
    logic [SYNC_W-1:0] raw_status;
    logic [SYNC_W-1:0] sync_status;

    assign raw_status = {framing_err_i, lane_err_i, lane_buf_i,
                         fabric_pll_lock_i, xcvr_pll_lock_i,
                         xcvr_reset_done_i};

    ptx_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .async_i  (raw_status),
        .sync_o   (sync_status)
    );

    // Named slices of the synchronised status.
    wire [3:0]               s_reset_done = sync_status[3:0];
    wire [1:0]               s_pll_lock   = sync_status[5:4];
    wire                     s_fabric     = sync_status[6];
    wire [2*NUM_LANES-1:0]   s_lane_buf   = sync_status[7 +: 2*NUM_LANES];
    wire [2*NUM_LANES-1:0]   s_lane_err   =
        sync_status[7 + 2*NUM_LANES +: 2*NUM_LANES];
    wire [2*NUM_STREAMS-1:0] s_framing    =
        sync_status[7 + 4*NUM_LANES +: 2*NUM_STREAMS];

    // The core's port owner flag is on this clock and needs no crossing.
    wire lock_flag = core_port_busy_i;

    // Transceiver status word; bits 15:7 stay at zero.
    logic [31:0] xcvr_status_word;
    logic [31:0] framing_word;

    always_comb begin
        xcvr_status_word = 32'h0000_0000;
        xcvr_status_word[ptx_pkg::RST_DONE01_LO +: 2] =
            s_reset_done[1:0];
        xcvr_status_word[ptx_pkg::RST_DONE23_LO +: 2] =
            s_reset_done[3:2];
        xcvr_status_word[ptx_pkg::PLL01_BIT]      = s_pll_lock[0];
        xcvr_status_word[ptx_pkg::PLL23_BIT]      = s_pll_lock[1];
        xcvr_status_word[ptx_pkg::FABRIC_PLL_BIT] = s_fabric;
        for (int l = 0; l < NUM_LANES; l++) begin
            xcvr_status_word[ptx_pkg::LANE_FIELD_LO +
                             ptx_pkg::LANE_STRIDE * l +: 4] =
                ptx_pkg::ptx_lane_stat_t'({s_lane_err[2*l +: 2],
                                           s_lane_buf[2*l +: 2]});
        end
    end

    // Framing codes only mean something on a 32-bit transceiver path.
    always_comb begin
        framing_word = 32'h0000_0000;
        if (XCVR_DATA_W == ptx_pkg::FRAMING_DATA_W) begin
            for (int s = 0; s < NUM_STREAMS; s++) begin
                framing_word[ptx_pkg::FRAME_STRIDE * s +: 2] =
                    s_framing[2*s +: 2];
            end
        end
    end

    // Software visible registers.
    ptx_pkg::ptx_cmd_t      cmd;
    logic [15:0]            htotal;
    logic [15:0]            vtotal;
    logic [ptx_pkg::IRQ_W-1:0] irq_status;
    logic [ptx_pkg::IRQ_W-1:0] irq_mask;
    logic                   ack;
    logic                   launch;
    logic                   eng_busy;
    ptx_pkg::ptx_cfg_resp_t resp;

    // Address decode of the current request.
    wire req       = avs_read_i | avs_write_i;
    wire hit_stat  = (avs_address_i == ptx_pkg::OFF_XCVR_STATUS);
    wire hit_cmd   = (avs_address_i == ptx_pkg::OFF_CFG_COMMAND);
    wire hit_rdata = (avs_address_i == ptx_pkg::OFF_CFG_RDATA);
    wire hit_lock  = (avs_address_i == ptx_pkg::OFF_CFG_LOCK);
    wire hit_ists  = (avs_address_i == ptx_pkg::OFF_IRQ_STATUS);
    wire hit_imask = (avs_address_i == ptx_pkg::OFF_IRQ_MASK);
    wire hit_frame = (avs_address_i == ptx_pkg::OFF_FRAMING);
    wire hit_htot  = (avs_address_i == ptx_pkg::OFF_S2_HTOTAL);
    wire hit_vtot  = (avs_address_i == ptx_pkg::OFF_S2_VTOTAL);

    // A command write is held off while the previous one is in flight,
    // so each accepted write maps to exactly one port transaction.
    wire stall = avs_write_i & hit_cmd & (eng_busy | launch);
    wire wr_en = avs_write_i & ack;

    assign avs_waitrequest_o = req & ~ack;

    // Read selection; unmapped addresses answer zero.
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_stat) begin
            rd_mux = xcvr_status_word;
        end else if (hit_cmd) begin
            rd_mux = cmd;
        end else if (hit_rdata) begin
            rd_mux = {16'h0000, resp.rdata};
        end else if (hit_lock) begin
            rd_mux[ptx_pkg::LOCK_BIT] = lock_flag;
        end else if (hit_ists) begin
            rd_mux[ptx_pkg::IRQ_W-1:0] = irq_status;
        end else if (hit_imask) begin
            rd_mux[ptx_pkg::IRQ_W-1:0] = irq_mask;
        end else if (hit_frame) begin
            rd_mux = framing_word;
        end else if (hit_htot) begin
            rd_mux = {16'h0000, htotal};
        end else if (hit_vtot) begin
            rd_mux = {16'h0000, vtotal};
        end
    end

    // One wait cycle per access, more while a command write is stalled; read data are registered with the ack.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack            <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            ack <= req & ~ack & ~stall;
            if (avs_read_i & ~ack) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // Writable registers; read-only offsets ignore writes.
    wire [31:0] cmd_next = be_merge(cmd, avs_writedata_i, avs_byteenable_i);
    wire [31:0] ht_next  = be_merge({16'h0000, htotal}, avs_writedata_i,
                                    avs_byteenable_i);
    wire [31:0] vt_next  = be_merge({16'h0000, vtotal}, avs_writedata_i,
                                    avs_byteenable_i);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd    <= ptx_pkg::CMD_RESET;
            htotal <= ptx_pkg::TOTAL_RESET;
            vtotal <= ptx_pkg::TOTAL_RESET;
            launch <= 1'b0;
        end else begin
            launch <= wr_en & hit_cmd;
            if (wr_en & hit_cmd) begin
                cmd <= cmd_next;
            end
            if (wr_en & hit_htot) begin
                htotal <= ht_next[15:0];
            end
            if (wr_en & hit_vtot) begin
                vtotal <= vt_next[15:0];
            end
        end
    end

    assign s2_htotal_o = htotal;
    assign s2_vtotal_o = vtotal;

    // Port engine; software is expected to wait for it before reading
    // the returned data, which a done interrupt also reports.
    ptx_cfg_port #(
        .NUM_CH (NUM_LANES)
    ) u_cfg_port (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .start_i  (launch),
        .cmd_i    (cmd),
        .hold_i   (lock_flag),
        .busy_o   (eng_busy),
        .resp_o   (resp),
        .en_o     (cfg_en_o),
        .we_o     (cfg_we_o),
        .addr_o   (cfg_addr_o),
        .wdata_o  (cfg_wdata_o),
        .rdy_i    (cfg_rdy_i),
        .rdata_i  (cfg_rdata_i)
    );

    // A framing code going from zero to nonzero on any stream is an event.
    logic [NUM_STREAMS-1:0] frame_seen;
    logic [NUM_STREAMS-1:0] frame_now;

    always_comb begin
        frame_now = '0;
        for (int s = 0; s < NUM_STREAMS; s++) begin
            frame_now[s] = |framing_word[ptx_pkg::FRAME_STRIDE * s +: 2];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frame_seen <= '0;
        end else begin
            frame_seen <= frame_now;
        end
    end

    // Events and write-one-to-clear; a set in the same cycle wins.
    logic [ptx_pkg::IRQ_W-1:0] irq_event;
    logic [ptx_pkg::IRQ_W-1:0] irq_clear;

    always_comb begin
        irq_event = '0;
        irq_event[ptx_pkg::IRQ_DONE_BIT]    = resp.done;
        irq_event[ptx_pkg::IRQ_FRAMING_BIT] = |(frame_now & ~frame_seen);
        irq_clear = '0;
        if (wr_en & hit_ists & avs_byteenable_i[0]) begin
            irq_clear = avs_writedata_i[ptx_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status <= '0;
            irq_mask   <= ptx_pkg::MASK_RESET;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            if (wr_en & hit_imask & avs_byteenable_i[0]) begin
                irq_mask <= avs_writedata_i[ptx_pkg::IRQ_W-1:0];
            end
        end
    end

    // Level interrupt while any unmasked event is pending.
    assign irq_o = |(irq_status & irq_mask);

endmodule

`default_nettype wire

/* File: test/ptx_props.sv */
`timescale 1ns/100ps
`default_nettype none

module ptx_props #(
    parameter int NUM_LANES = 4
) (
    input wire logic        clock_i,             // Clock.
    input wire logic        arst_n_i,            // Reset.
    input wire logic [11:0] avs_address_i,       // Address.
    input wire logic        avs_read_i,          // Read.
    input wire logic        avs_write_i,         // Write.
    input wire logic [31:0] avs_writedata_i,     // Write data.
    input wire logic [3:0]  avs_byteenable_i,    // Byte lanes.
    input wire logic [31:0] avs_readdata_o,      // Read data.
    input wire logic        avs_waitrequest_o,   // Stall.
    input wire logic        core_port_busy_i,    // Core owns port.
    input wire logic [NUM_LANES-1:0] cfg_en_o,   // Enables.
    input wire logic        cfg_we_o,            // Port write.
    input wire logic [7:0]  cfg_addr_o,          // Port address.
    input wire logic [15:0] cfg_wdata_o,         // Port data.
    input wire logic [15:0] s2_htotal_o          // Line length.
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    // Transfers that finish at this edge.
    wire logic rd_ok = avs_read_i && !avs_waitrequest_o;
    wire logic wr_ok = avs_write_i && !avs_waitrequest_o;

    // A full command write, then a free port two cycles later.
    sequence cmd_acc_s;
        wr_ok && avs_address_i == ptx_pkg::OFF_CFG_COMMAND &&
        avs_byteenable_i == 4'hF;
    endsequence
    sequence port_free_s;
        ##2 !core_port_busy_i;
    endsequence

    chk_cmd_launch: assert property (
        cmd_acc_s ##0 port_free_s |=> cfg_en_o == 4'hF &&
        cfg_addr_o == $past(avs_writedata_i[7:0], 3) &&
        cfg_we_o == $past(avs_writedata_i[15], 3))
        else $error("command not launched as written");
    chk_read_wait: assert property (
        avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("read stalled beyond one cycle");
    chk_status_zero: assert property (
        rd_ok && avs_address_i == ptx_pkg::OFF_XCVR_STATUS
        |-> avs_readdata_o[15:7] == 9'h000)
        else $error("unused status bits set");
    chk_framing_zero: assert property (
        rd_ok && avs_address_i == ptx_pkg::OFF_FRAMING
        |-> (avs_readdata_o & 32'hFCFCFCFC) == 32'h00000000)
        else $error("framing spare bits set");
    chk_en_all: assert property (
        cfg_en_o != 4'h0 |-> cfg_en_o == 4'hF)
        else $error("channels enabled unequally");
    chk_en_pulse: assert property (
        cfg_en_o != 4'h0 |=> cfg_en_o == 4'h0)
        else $error("port enable longer than one cycle");
    chk_read_payload: assert property (
        cfg_en_o != 4'h0 && !cfg_we_o |-> cfg_wdata_o == 16'h0000)
        else $error("read carries payload");
    chk_core_hold: assert property (
        $past(core_port_busy_i) |-> cfg_en_o == 4'h0)
        else $error("port used while core owns it");
    chk_htotal_store: assert property (
        wr_ok && avs_address_i == ptx_pkg::OFF_S2_HTOTAL &&
        avs_byteenable_i == 4'hF
        |=> s2_htotal_o == $past(avs_writedata_i[15:0]))
        else $error("line length not stored");
endmodule

bind ptx_regs ptx_props #(.NUM_LANES(NUM_LANES)) u_props (.*);

`default_nettype wire

/* File: test/ptx_port_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ptx_port_model (
    input  wire logic        clock_i,  // Block clock.
    input  wire logic        slow_i,   // Answer late when high.
    input  wire logic [3:0]  en_i,     // Enable per channel.
    input  wire logic        we_i,     // Write enable.
    input  wire logic [7:0]  addr_i,   // Port address.
    input  wire logic [15:0] wdata_i,  // Write data.
    output logic      [3:0]  rdy_o,    // Ready per channel.
    output logic      [15:0] rdata_o   // Channel 0 read data.
);
    logic [15:0] mem [256];
    logic [3:0]  cnt [4];
    logic [15:0] last;

    // Unwritten words hold an address pattern that reads can check.
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
        for (int c = 0; c < 4; c++) cnt[c] = 4'h0;
        rdy_o = 4'h0;
        rdata_o = 16'h0000;
        last = 16'h0000;
    end

    // Per-channel delays; between answers data show the inverse.
    always @(posedge clock_i) begin
        rdy_o <= 4'h0;
        rdata_o <= ~last;
        if (en_i != 4'h0 && we_i) mem[addr_i] <= wdata_i;
        for (int c = 0; c < 4; c++) begin
            if (en_i[c]) cnt[c] <= slow_i ? 4'(9 + c) : 4'(1 + c);
            else if (cnt[c] != 4'h0) cnt[c] <= cnt[c] - 4'h1;
            if (cnt[c] == 4'h1) rdy_o[c] <= 1'b1;
        end
        if (cnt[0] == 4'h1) begin
            rdata_o <= mem[addr_i];
            last <= mem[addr_i];
        end
    end
endmodule

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam int LIMIT = 5000;
    logic        clock_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [11:0] avs_address_i = 12'h000;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        irq_o;
    logic [3:0]  xcvr_reset_done_i = 4'h0;
    logic [1:0]  xcvr_pll_lock_i = 2'h0;
    logic        fabric_pll_lock_i = 1'b0;
    logic [7:0]  lane_buf_i = 8'h00, lane_err_i = 8'h00, framing_err_i = 8'h00;
    logic        core_port_busy_i = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  cfg_en_o;
    logic [3:0]  cfg_rdy_i;
    logic        cfg_we_o;
    logic [7:0]  cfg_addr_o;
    logic [15:0] cfg_wdata_o, cfg_rdata_i, s2_htotal_o, s2_vtotal_o;
    int          mismatches = 0, num_checks = 0, cycles = 0;

    // Free-running block clock.
    always #25 clock_i = ~clock_i;

    ptx_regs DUT (.*);

    ptx_port_model u_port (
        .clock_i(clock_i),
        .slow_i(slow),
        .en_i(cfg_en_o),
        .we_i(cfg_we_o),
        .addr_i(cfg_addr_o),
        .wdata_i(cfg_wdata_o),
        .rdy_o(cfg_rdy_i),
        .rdata_o(cfg_rdata_i)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // One transfer; waitrequest is taken at the rising edge.
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(n, e, q);
    endtask

    task automatic irqc(input logic e);
        @(negedge clock_i);
        chk("irq", {31'h0, e}, {31'h0, irq_o});
        @(posedge clock_i);
    endtask

    task automatic t_reset();
        rdc("htotal", ptx_pkg::OFF_S2_HTOTAL, 32'h0);
        rdc("mask", ptx_pkg::OFF_IRQ_MASK, 32'h0);
        irqc(1'b0);
        wr(12'h600, 32'hFFFFFFFF);
        rdc("unmapped", 12'h600, 32'h0);
        $display("test reset finished");
    endtask

    task automatic t_status();
        logic [31:0] e;
        for (int p = 0; p < 2; p++) begin
            xcvr_reset_done_i <= p ? 4'h5 : 4'hA;
            xcvr_pll_lock_i <= p ? 2'h1 : 2'h2;
            fabric_pll_lock_i <= p[0];
            lane_buf_i <= p ? 8'h1B : 8'hE4;
            lane_err_i <= p ? 8'hC6 : 8'h39;
            repeat (4) @(posedge clock_i);
            e = {25'h0, fabric_pll_lock_i, xcvr_pll_lock_i,
                 xcvr_reset_done_i};
            for (int l = 0; l < 4; l++) begin
                e[16 + 4 * l +: 2] = lane_buf_i[2 * l +: 2];
                e[18 + 4 * l +: 2] = lane_err_i[2 * l +: 2];
            end
            wr(ptx_pkg::OFF_XCVR_STATUS, 32'hFFFFFFFF);
            rdc("status", ptx_pkg::OFF_XCVR_STATUS, e);
        end
        $display("test status finished");
    endtask

    task automatic t_framing();
        framing_err_i <= 8'hE4;
        repeat (4) @(posedge clock_i);
        rdc("framing", ptx_pkg::OFF_FRAMING, 32'h03020100);
        irqc(1'b0);
        wr(ptx_pkg::OFF_IRQ_MASK, 32'h2);
        irqc(1'b1);
        rdc("event", ptx_pkg::OFF_IRQ_STATUS, 32'h2);
        wr(ptx_pkg::OFF_IRQ_STATUS, 32'h2);
        irqc(1'b0);
        rdc("cleared", ptx_pkg::OFF_IRQ_STATUS, 32'h0);
        $display("test framing finished");
    endtask

    // Poll the lock bit, launch, then wait for the done interrupt.
    task automatic cmd(input logic [31:0] c);
        logic [31:0] q;
        q = 32'h1;
        while (q[0] !== 1'b0) begin
            bus(1'b0, ptx_pkg::OFF_CFG_LOCK, 32'h0, 4'hF, q);
        end
        wr(ptx_pkg::OFF_CFG_COMMAND, c);
        repeat (10) @(posedge clock_i);
        while (irq_o !== 1'b1) @(negedge clock_i);
        @(posedge clock_i);
        wr(ptx_pkg::OFF_IRQ_STATUS, 32'h1);
    endtask

    task automatic t_cfg();
        logic [15:0] v;
        wr(ptx_pkg::OFF_IRQ_MASK, 32'h1);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            v = s ? 16'h4321 : 16'hBEEF;
            cmd({v, 16'h803C});
            rdc("command", ptx_pkg::OFF_CFG_COMMAND, {v, 16'h803C});
            cmd(32'h1234003C);
            rdc("rdata", ptx_pkg::OFF_CFG_RDATA, {16'h0, v});
        end
        cmd(32'hFFFF0055);
        rdc("rdata", ptx_pkg::OFF_CFG_RDATA, 32'h000055AA);
        $display("test config port finished");
    endtask

    task automatic t_lock();
        core_port_busy_i <= 1'b1;
        @(posedge clock_i);
        rdc("lock", ptx_pkg::OFF_CFG_LOCK, 32'h1);
        core_port_busy_i <= 1'b0;
        @(posedge clock_i);
        rdc("unlock", ptx_pkg::OFF_CFG_LOCK, 32'h0);
        $display("test lock finished");
    endtask

    task automatic t_totals();
        logic [31:0] q;
        wr(ptx_pkg::OFF_S2_HTOTAL, 32'h00001E2D);
        wr(ptx_pkg::OFF_S2_VTOTAL, 32'h00000465);
        bus(1'b1, ptx_pkg::OFF_S2_HTOTAL, 32'h0000AB00, 4'h2, q);
        rdc("htotal", ptx_pkg::OFF_S2_HTOTAL, 32'h0000AB2D);
        chk("htotal out", 32'h0000AB2D, {16'h0, s2_htotal_o});
        chk("vtotal out", 32'h00000465, {16'h0, s2_vtotal_o});
        rdc("vtotal", ptx_pkg::OFF_S2_VTOTAL, 32'h00000465);
        $display("test totals finished");
    endtask

    // A hang is cut short here and reported as a mismatch.
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("timeout after %0d cycles", cycles);
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_status();
        t_framing();
        t_cfg();
        t_lock();
        t_totals();
        wrap_up();
    end
endmodule

`default_nettype wire
